//--- inc/ubc_cfg.svh
`ifndef UBC_CFG_SVH
`define UBC_CFG_SVH

// register offsets
`define UBC_OFF_ISR       8'hB0
`define UBC_OFF_CTL       8'hB4
`define UBC_OFF_EP0RX     8'hB5
`define UBC_OFF_EP0TX     8'hB6
`define UBC_OFF_EP1RX     8'hB7
`define UBC_OFF_EP1TX     8'hC7
`define UBC_OFF_WCA_HI    8'hCE
`define UBC_OFF_WCA_LO    8'hCF
`define UBC_OFF_WCB_HI    8'hD1
`define UBC_OFF_WCB_LO    8'hD2
`define UBC_OFF_RLA_HI    8'hD3
`define UBC_OFF_RLA_LO    8'hD4
`define UBC_OFF_RLB_HI    8'hD5
`define UBC_OFF_RLB_LO    8'hD6

// control register bit positions
`define UBC_BIT_DIR       7
`define UBC_BIT_WRQ       6
`define UBC_BIT_WRSEL     5
`define UBC_BIT_RDSEL     4
`define UBC_BIT_STALL_RX  3
`define UBC_BIT_STALL_TX  2
`define UBC_BIT_RDQ       1
`define UBC_BIT_ENABLE    0

// interrupt status zero bit positions
`define UBC_ISR_RD_A      0
`define UBC_ISR_RD_B      1
`define UBC_ISR_ERR       2

// reset values
`define UBC_RST_BYTE      8'h00
`define UBC_RST_CNT7      7'h00
`define UBC_RST_CNT10     10'h000
`define UBC_RST_ISR       3'h0

// buffer geometry
`define UBC_FULL_BUFFER   10'h200
`define UBC_BUF_A_BASE    11'h100
`define UBC_BUF_B_BASE    11'h300
`define UBC_EP0RX_BASE    11'h000
`define UBC_EP0TX_BASE    11'h040
`define UBC_EP1RX_BASE    11'h080
`define UBC_EP1TX_BASE    11'h0C0

`endif

//--- inc/ubc_pkg.sv
package ubc_pkg;
	typedef logic [7:0] ubc_byte_t;
	typedef logic [9:0] ubc_count_t;
	typedef enum logic [0:0] {
		UBC_RD_IDLE = 1'b0,
		UBC_RD_RUN  = 1'b1
	} ubc_rd_state_t;
endpackage : ubc_pkg

//--- inc/ubc_reg_if.sv
`timescale 1ns/1ns
interface ubc_reg_if;
	ubc_pkg::ubc_byte_t addr;
	ubc_pkg::ubc_byte_t wdata;
	logic               wr;
	logic               rd;
	ubc_pkg::ubc_byte_t rdata;

	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport fw  (output addr, output wdata, output wr, output rd, input rdata);
endinterface : ubc_reg_if

//--- rtl/ubc_count_reg.sv
`timescale 1ns/1ns
`include "ubc_cfg.svh"
module ubc_count_reg (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       sw_we,
	input  wire logic [6:0] sw_d,
	input  wire logic       hw_we,
	input  wire logic [6:0] hw_d,
	input  wire logic       clr,
	output logic      [6:0] q
);
	logic [6:0] cnt_reg;

	// a hardware load in the clearing cycle wins so a packet is never lost
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cnt_reg <= `UBC_RST_CNT7;
		else if (hw_we)
			cnt_reg <= hw_d;
		else if (clr)
			cnt_reg <= `UBC_RST_CNT7;
		else if (sw_we)
			cnt_reg <= sw_d;
	end

	assign q = cnt_reg;
endmodule : ubc_count_reg

//--- rtl/ubc_device.sv
`timescale 1ns/1ns
`include "ubc_cfg.svh"
module ubc_device #(
	parameter bit SHARED_STALL = 1'b0
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	ubc_reg_if.dev           bus,
	input  wire logic        usb_reset,
	input  wire logic        sie_ep2_en_tx,
	input  wire logic        sie_ep2_en_rx,
	input  wire logic        sie_stall_tx_set,
	input  wire logic        sie_stall_rx_set,
	input  wire logic        clear_feature_tx,
	input  wire logic        clear_feature_rx,
	input  wire logic        set_configuration,
	input  wire logic        setup_received,
	input  wire logic        in_token,
	input  wire logic        out_token,
	input  wire logic        ep0_rx_done,
	input  wire logic [6:0]  ep0_rx_end_addr,
	input  wire logic        ep1_rx_done,
	input  wire logic [6:0]  ep1_rx_end_addr,
	input  wire logic        wr_byte,
	input  wire logic        rd_byte_ack,
	output logic             dir,
	output logic             ep2_stall_tx,
	output logic             ep2_stall_rx,
	output logic             wr_buf,
	output logic             rd_start,
	output logic             rd_buf,
	output logic             rd_active,
	output logic      [10:0] rd_addr,
	output logic      [6:0]  ep0_tx_len,
	output logic      [6:0]  ep1_tx_len
);
	ubc_pkg::ubc_rd_state_t state_reg;
	ubc_pkg::ubc_count_t    wcnt_reg [2];
	ubc_pkg::ubc_count_t    rlen_reg [2];
	ubc_pkg::ubc_count_t    rd_cnt_reg;
	ubc_pkg::ubc_count_t    rd_len_reg;
	ubc_pkg::ubc_byte_t     rdata_reg;
	ubc_pkg::ubc_byte_t     rd_val;
	logic [2:0]             isr_reg;
	logic [2:0]             isr_set;
	logic [2:0]             isr_clr;
	logic                   dir_reg;
	logic                   wr_sel_reg;
	logic                   rd_sel_reg;
	logic                   stall_tx_reg;
	logic                   stall_rx_reg;
	logic                   rd_start_reg;
	logic                   rd_active_reg;
	logic [10:0]            rd_addr_reg;
	logic                   ctl_wr;
	logic                   rd_go;
	logic                   wr_go;
	logic                   rd_done;
	logic                   stall_tx_set;
	logic                   stall_rx_set;
	logic                   stall_tx_clr;
	logic                   stall_rx_clr;
	logic [6:0]             ep0_rx_q;
	logic [6:0]             ep1_rx_q;

	assign ctl_wr = bus.wr && (bus.addr == `UBC_OFF_CTL);
	assign rd_go  = ctl_wr && bus.wdata[`UBC_BIT_RDQ];
	assign wr_go  = ctl_wr && bus.wdata[`UBC_BIT_WRQ];
	assign rd_done = (state_reg == ubc_pkg::UBC_RD_RUN) && (rd_cnt_reg == rd_len_reg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			dir_reg <= 1'b0;
		else if (ctl_wr)
			dir_reg <= bus.wdata[`UBC_BIT_DIR];
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_sel_reg  <= 1'b0;
			wcnt_reg[0] <= `UBC_RST_CNT10;
			wcnt_reg[1] <= `UBC_RST_CNT10;
		end else if (wr_go) begin
			wr_sel_reg                         <= bus.wdata[`UBC_BIT_WRSEL];
			wcnt_reg[bus.wdata[`UBC_BIT_WRSEL]] <= `UBC_RST_CNT10;
		end else if (wr_byte && (wcnt_reg[wr_sel_reg] != `UBC_FULL_BUFFER)) begin
			// saturates at a full buffer so bit nine is the full flag
			wcnt_reg[wr_sel_reg] <= wcnt_reg[wr_sel_reg] + 10'h001;
		end
	end

	// firmware-loaded readout lengths; bit nine is the full-buffer flag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rlen_reg[0] <= `UBC_RST_CNT10;
			rlen_reg[1] <= `UBC_RST_CNT10;
		end else if (bus.wr) begin
			case (bus.addr)
				`UBC_OFF_RLA_HI: rlen_reg[0][9:8] <= bus.wdata[1:0];
				`UBC_OFF_RLA_LO: rlen_reg[0][7:0] <= bus.wdata;
				`UBC_OFF_RLB_HI: rlen_reg[1][9:8] <= bus.wdata[1:0];
				`UBC_OFF_RLB_LO: rlen_reg[1][7:0] <= bus.wdata;
				default: ;
			endcase
		end
	end

	// readout start; a start while busy is dropped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg     <= ubc_pkg::UBC_RD_IDLE;
			rd_sel_reg    <= 1'b0;
			rd_len_reg    <= `UBC_RST_CNT10;
			rd_cnt_reg    <= `UBC_RST_CNT10;
			rd_addr_reg   <= 11'h000;
			rd_start_reg  <= 1'b0;
			rd_active_reg <= 1'b0;
		end else begin
			rd_start_reg <= 1'b0;
			case (state_reg)
				ubc_pkg::UBC_RD_IDLE: begin
					if (rd_go) begin
						// length latched so later count writes do not disturb it
						rd_sel_reg    <= bus.wdata[`UBC_BIT_RDSEL];
						rd_len_reg    <= rlen_reg[bus.wdata[`UBC_BIT_RDSEL]][9] ?
							`UBC_FULL_BUFFER :
							{1'b0, rlen_reg[bus.wdata[`UBC_BIT_RDSEL]][8:0]};
						rd_cnt_reg    <= `UBC_RST_CNT10;
						rd_addr_reg   <= bus.wdata[`UBC_BIT_RDSEL] ?
							`UBC_BUF_B_BASE : `UBC_BUF_A_BASE;
						rd_start_reg  <= 1'b1;
						rd_active_reg <= 1'b1;
						state_reg     <= ubc_pkg::UBC_RD_RUN;
					end
				end
				ubc_pkg::UBC_RD_RUN: begin
					if (rd_done) begin
						rd_active_reg <= 1'b0;
						state_reg     <= ubc_pkg::UBC_RD_IDLE;
					end else if (rd_byte_ack) begin
						rd_cnt_reg  <= rd_cnt_reg + 10'h001;
						rd_addr_reg <= rd_addr_reg + 11'h001;
					end
				end
				default: state_reg <= ubc_pkg::UBC_RD_IDLE;
			endcase
		end
	end

	always_comb begin
		isr_set = 3'h0;
		isr_clr = 3'h0;
		isr_set[`UBC_ISR_RD_A] = rd_done && !rd_sel_reg;
		isr_set[`UBC_ISR_RD_B] = rd_done && rd_sel_reg;
		isr_set[`UBC_ISR_ERR]  = (dir_reg && out_token) || (!dir_reg && in_token);
		if (bus.wr && (bus.addr == `UBC_OFF_ISR))
			isr_clr = bus.wdata[2:0];
		if (rd_go) begin
			isr_clr[`UBC_ISR_RD_B] = isr_clr[`UBC_ISR_RD_B] | bus.wdata[`UBC_BIT_RDSEL];
			isr_clr[`UBC_ISR_RD_A] = isr_clr[`UBC_ISR_RD_A] | !bus.wdata[`UBC_BIT_RDSEL];
		end
	end

	// set beats clear so a completion in the clearing cycle survives
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			isr_reg <= `UBC_RST_ISR;
		else
			isr_reg <= (isr_reg & ~isr_clr) | isr_set;
	end

	// set by engine or firmware; firmware zero writes do nothing
	assign stall_tx_set = sie_stall_tx_set || (ctl_wr && bus.wdata[`UBC_BIT_STALL_TX]);
	assign stall_rx_set = sie_stall_rx_set || (ctl_wr && bus.wdata[`UBC_BIT_STALL_RX]);
	// only three clearing events; shared clears both
	assign stall_tx_clr = clear_feature_tx || set_configuration || usb_reset ||
		(SHARED_STALL && clear_feature_rx);
	assign stall_rx_clr = clear_feature_rx || set_configuration || usb_reset;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stall_tx_reg <= 1'b0;
			stall_rx_reg <= 1'b0;
		end else begin
			stall_tx_reg <= stall_tx_set || (stall_tx_reg && !stall_tx_clr);
			stall_rx_reg <= !SHARED_STALL &&
				(stall_rx_set || (stall_rx_reg && !stall_rx_clr));
		end
	end

	// loaded from the ending address only at transfer end
	ubc_count_reg u_ep0_rx (
		.mclk  (mclk),
		.rst   (rst),
		.sw_we (1'b0),
		.sw_d  (`UBC_RST_CNT7),
		.hw_we (ep0_rx_done),
		.hw_d  (ep0_rx_end_addr),
		.clr   (1'b0),
		.q     (ep0_rx_q)
	);

	// a zero here sends an empty packet on request
	ubc_count_reg u_ep0_tx (
		.mclk  (mclk),
		.rst   (rst),
		.sw_we (bus.wr && (bus.addr == `UBC_OFF_EP0TX)),
		.sw_d  (bus.wdata[6:0]),
		.hw_we (1'b0),
		.hw_d  (`UBC_RST_CNT7),
		.clr   (1'b0),
		.q     (ep0_tx_len)
	);

	// cleared by a setup on endpoint zero
	ubc_count_reg u_ep1_rx (
		.mclk  (mclk),
		.rst   (rst),
		.sw_we (1'b0),
		.sw_d  (`UBC_RST_CNT7),
		.hw_we (ep1_rx_done),
		.hw_d  (ep1_rx_end_addr),
		.clr   (setup_received),
		.q     (ep1_rx_q)
	);

	ubc_count_reg u_ep1_tx (
		.mclk  (mclk),
		.rst   (rst),
		.sw_we (bus.wr && (bus.addr == `UBC_OFF_EP1TX)),
		.sw_d  (bus.wdata[6:0]),
		.hw_we (1'b0),
		.hw_d  (`UBC_RST_CNT7),
		.clr   (1'b0),
		.q     (ep1_tx_len)
	);

	always_comb begin
		rd_val = `UBC_RST_BYTE;
		case (bus.addr)
			`UBC_OFF_ISR:   rd_val = {5'h00, isr_reg};
			// current buffers, qualifiers zero, enable status
			`UBC_OFF_CTL:   rd_val = {dir_reg, 1'b0, wr_sel_reg, rd_sel_reg,
				stall_rx_reg, stall_tx_reg, 1'b0, sie_ep2_en_tx | sie_ep2_en_rx};
			`UBC_OFF_EP0RX: rd_val = {1'b0, ep0_rx_q};
			`UBC_OFF_EP0TX: rd_val = {1'b0, ep0_tx_len};
			`UBC_OFF_EP1RX: rd_val = {1'b0, ep1_rx_q};
			`UBC_OFF_EP1TX: rd_val = {1'b0, ep1_tx_len};
			// full flag and count bit eight
			`UBC_OFF_WCA_HI: rd_val = {6'h00, wcnt_reg[0][9:8]};
			`UBC_OFF_WCA_LO: rd_val = wcnt_reg[0][7:0];
			`UBC_OFF_WCB_HI: rd_val = {6'h00, wcnt_reg[1][9:8]};
			`UBC_OFF_WCB_LO: rd_val = wcnt_reg[1][7:0];
			`UBC_OFF_RLA_HI: rd_val = {6'h00, rlen_reg[0][9:8]};
			`UBC_OFF_RLA_LO: rd_val = rlen_reg[0][7:0];
			`UBC_OFF_RLB_HI: rd_val = {6'h00, rlen_reg[1][9:8]};
			`UBC_OFF_RLB_LO: rd_val = rlen_reg[1][7:0];
			default:         rd_val = `UBC_RST_BYTE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata_reg <= `UBC_RST_BYTE;
		else
			rdata_reg <= bus.rd ? rd_val : `UBC_RST_BYTE;
	end

	assign bus.rdata    = rdata_reg;
	assign dir          = dir_reg;
	assign ep2_stall_tx = stall_tx_reg;
	// shared variant mirrors transmit stall onto receive
	assign ep2_stall_rx = SHARED_STALL ? stall_tx_reg : stall_rx_reg;
	assign wr_buf       = wr_sel_reg;
	assign rd_start     = rd_start_reg;
	assign rd_buf       = rd_sel_reg;
	assign rd_active    = rd_active_reg;
	assign rd_addr      = rd_addr_reg;
endmodule : ubc_device

//--- rtl/ubc_host.sv
`timescale 1ns/1ns
`include "ubc_cfg.svh"
module ubc_host (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] cmd_addr,
	input  wire logic [7:0] cmd_wdata,
	input  wire logic       cmd_wr,
	input  wire logic       cmd_rd,
	output logic      [7:0] cmd_rdata,
	ubc_reg_if.fw           bus
);
	logic dir_reg;
	logic ctl_wr;
	logic dir_change;

	assign ctl_wr     = cmd_wr && (cmd_addr == `UBC_OFF_CTL);
	assign dir_change = ctl_wr && (cmd_wdata[`UBC_BIT_DIR] != dir_reg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			dir_reg <= 1'b0;
		else if (ctl_wr)
			dir_reg <= cmd_wdata[`UBC_BIT_DIR];
	end

	// passed through unregistered so read data still land one cycle after the strobe
	assign bus.addr = cmd_addr;
	assign bus.wr   = cmd_wr;
	assign bus.rd   = cmd_rd;
	// a direction change always carries a write qualifier (WRQ); the write select comes from the firmware's own write
	assign bus.wdata = dir_change ? (cmd_wdata | (8'h01 << `UBC_BIT_WRQ)) : cmd_wdata;
	// flags settle on the write edge, so a read one cycle later is safe
	assign cmd_rdata = bus.rdata;
endmodule : ubc_host

//--- verif/ubc_monitor.sv
`timescale 1ns/1ns
module ubc_monitor (
	input wire logic               mclk,
	input wire logic               rst,
	input wire ubc_pkg::ubc_byte_t addr,
	input wire ubc_pkg::ubc_byte_t wdata,
	input wire logic               wr,
	input wire logic               rd,
	input wire ubc_pkg::ubc_byte_t rdata
);
	logic               rd_reg;
	ubc_pkg::ubc_byte_t a_reg;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// rdata belongs to the address strobed one cycle earlier
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_reg <= 1'b0;
			a_reg  <= 8'h00;
		end else begin
			rd_reg <= rd;
			a_reg  <= addr;
		end
	end
	a_read_idle_zero: assert property (!rd_reg |-> rdata == 8'h00)
		else $error("rdata not zero outside read cycle");
	a_ctl_qual_zero: assert property (rd_reg && a_reg == 8'hB4 |-> !rdata[6] && !rdata[1])
		else $error("control qualifier bit read nonzero");
	a_cnt_resv_zero: assert property (rd_reg && a_reg inside {8'hB5, 8'hB6, 8'hB7, 8'hC7}
		|-> !rdata[7])
		else $error("endpoint count bit 7 read nonzero");
	a_wca_resv_zero: assert property (rd_reg && a_reg == 8'hCE |-> rdata[7:2] == 6'h00)
		else $error("write count upper reserved bits nonzero");
	a_hi_resv_zero: assert property (rd_reg && a_reg inside {8'hD1, 8'hD3, 8'hD5}
		|-> rdata[7:2] == 6'h00)
		else $error("upper count reserved bits nonzero");
	a_isr_resv_zero: assert property (rd_reg && a_reg == 8'hB0 |-> rdata[7:3] == 5'h00)
		else $error("status reserved bits nonzero");
	a_unmapped_zero: assert property (rd_reg && !(a_reg inside {8'hB0, 8'hB4, 8'hB5, 8'hB6,
		8'hB7, 8'hC7, 8'hCE, 8'hCF, [8'hD1:8'hD6]}) |-> rdata == 8'h00)
		else $error("unmapped address read nonzero");
	a_ep0tx_readback: assert property (wr && addr == 8'hB6 ##1 !wr ##1 rd && addr == 8'hB6
		|=> rdata == ($past(wdata, 3) & 8'h7F))
		else $error("endpoint 0 transmit count readback wrong");
	a_ep1tx_readback: assert property (wr && addr == 8'hC7 ##1 !wr ##1 rd && addr == 8'hC7
		|=> rdata == ($past(wdata, 3) & 8'h7F))
		else $error("endpoint 1 transmit count readback wrong");
	c_full_buffer: cover property (rd_reg && a_reg == 8'hCE && rdata[1]);
	c_both_done: cover property (rd_reg && a_reg == 8'hB0 && rdata == 8'h03);
	c_ep0tx_rw: cover property (wr && addr == 8'hB6 ##2 rd && addr == 8'hB6);
endmodule : ubc_monitor

//--- verif/usb_endpoint_buffer_control_tb.sv
`timescale 1ns/1ns
module usb_endpoint_buffer_control_tb;
	localparam logic [23:0] ROWS [9] = '{24'hB6FF7F, 24'hB60000, 24'hC7C545, 24'hB5FF00,
		24'hB7FF00, 24'hCEFF00, 24'h00FF00, 24'hD45A5A, 24'hD3FF03};
	localparam logic [7:0] REGS [14] = '{8'hB0, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hC7, 8'hCE,
		8'hCF, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6};
	logic        mclk;
	logic        rst;
	logic [7:0]  ca;
	logic [7:0]  cw;
	logic [7:0]  crd;
	logic        cwr;
	logic        crs;
	logic [12:0] ev;
	logic        en_tx;
	logic        en_rx;
	logic [6:0]  e0a;
	logic [6:0]  e1a;
	logic        dir;
	logic        stx;
	logic        srx;
	logic        stx_s;
	logic        srx_s;
	logic        wbuf;
	logic        rstart;
	logic        rbuf;
	logic        ract;
	logic [10:0] raddr;
	logic [6:0]  l0;
	logic [6:0]  l1;
	int          fails;
	int          samples_checked;
	int          cyc;
	ubc_reg_if bus_if ();
	// second device in the shared-stall variant follows the same bus traffic
	ubc_reg_if bus_s_if ();
	assign bus_s_if.addr  = bus_if.addr;
	assign bus_s_if.wdata = bus_if.wdata;
	assign bus_s_if.wr    = bus_if.wr;
	assign bus_s_if.rd    = bus_if.rd;
	ubc_device #(.SHARED_STALL(1'b1)) ubc_device_shared_i (.mclk(mclk), .rst(rst),
		.bus(bus_s_if), .usb_reset(ev[0]), .sie_ep2_en_tx(en_tx), .sie_ep2_en_rx(en_rx),
		.sie_stall_tx_set(ev[1]), .sie_stall_rx_set(ev[2]), .clear_feature_tx(ev[3]),
		.clear_feature_rx(ev[4]), .set_configuration(ev[5]), .setup_received(ev[6]),
		.in_token(ev[7]), .out_token(ev[8]), .ep0_rx_done(ev[9]), .ep0_rx_end_addr(e0a),
		.ep1_rx_done(ev[10]), .ep1_rx_end_addr(e1a), .wr_byte(ev[11]), .rd_byte_ack(ev[12]),
		.dir(), .ep2_stall_tx(stx_s), .ep2_stall_rx(srx_s), .wr_buf(), .rd_start(),
		.rd_buf(), .rd_active(), .rd_addr(), .ep0_tx_len(), .ep1_tx_len());
	ubc_host ubc_host_i (.mclk(mclk), .rst(rst), .cmd_addr(ca), .cmd_wdata(cw), .cmd_wr(cwr),
		.cmd_rd(crs), .cmd_rdata(crd), .bus(bus_if));
	ubc_device ubc_device_i (.mclk(mclk), .rst(rst), .bus(bus_if), .usb_reset(ev[0]),
		.sie_ep2_en_tx(en_tx), .sie_ep2_en_rx(en_rx), .sie_stall_tx_set(ev[1]),
		.sie_stall_rx_set(ev[2]), .clear_feature_tx(ev[3]), .clear_feature_rx(ev[4]),
		.set_configuration(ev[5]), .setup_received(ev[6]), .in_token(ev[7]),
		.out_token(ev[8]), .ep0_rx_done(ev[9]), .ep0_rx_end_addr(e0a), .ep1_rx_done(ev[10]),
		.ep1_rx_end_addr(e1a), .wr_byte(ev[11]), .rd_byte_ack(ev[12]), .dir(dir),
		.ep2_stall_tx(stx), .ep2_stall_rx(srx), .wr_buf(wbuf), .rd_start(rstart),
		.rd_buf(rbuf), .rd_active(ract), .rd_addr(raddr), .ep0_tx_len(l0), .ep1_tx_len(l1));
	ubc_monitor ubc_monitor_i (.mclk(mclk), .rst(rst), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic wc(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) begin
			ca <= a;
			cw <= d;
			cwr <= 1'b1;
		end
		@(posedge mclk) cwr <= 1'b0;
	endtask : wc
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk) begin
			ca <= a;
			crs <= 1'b1;
		end
		@(posedge mclk) crs <= 1'b0;
		#1 check($sformatf("reg %h", a), {8'h00, crd}, {8'h00, e});
	endtask : rc
	// side pulses held for n cycles, then three quiet cycles for the readout to settle
	task automatic hold(input logic [12:0] m, input int n);
		@(posedge mclk) ev <= m;
		repeat (n) @(posedge mclk);
		ev <= 13'h0000;
		repeat (3) @(posedge mclk);
	endtask : hold
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ceiling well above the roughly 800 cycles the sequence needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			final_report;
		end
	end
	initial begin
		{rst, ca, cw, cwr, crs, ev, en_tx, en_rx, e0a, e1a} = '0;
		rst = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		foreach (REGS[i]) rc(REGS[i], 8'h00);
		$display("test reset done");
		foreach (ROWS[i]) begin
			wc(ROWS[i][23:16], ROWS[i][15:8]);
			rc(ROWS[i][23:16], ROWS[i][7:0]);
		end
		check("ep1 length", {9'h000, l1}, 16'h0045);
		check("ep0 length", {9'h000, l0}, 16'h0000);
		$display("test table done");
		wc(8'hD3, 8'h00);
		wc(8'hD4, 8'h02);
		wc(8'hB4, 8'h02);
		#1 check("start", {rstart, ract, 3'h0, raddr}, 16'hC100);
		wc(8'hD4, 8'h09);
		hold(13'h1000, 2);
		check("end A", {ract, 4'h0, raddr}, 16'h0102);
		rc(8'hB0, 8'h01);
		rc(8'hB4, 8'h00);
		wc(8'hD6, 8'h01);
		wc(8'hB4, 8'h12);
		#1 check("start B", {rbuf, 4'h0, raddr}, 16'h8300);
		hold(13'h1000, 1);
		rc(8'hB0, 8'h03);
		rc(8'hB4, 8'h10);
		wc(8'hB4, 8'h00);
		#1 check("no start", {15'h0000, rstart}, 16'h0000);
		rc(8'hB4, 8'h10);
		wc(8'hB4, 8'h02);
		rc(8'hB0, 8'h02);
		rc(8'hB4, 8'h00);
		hold(13'h1000, 9);
		rc(8'hB0, 8'h03);
		wc(8'hB0, 8'h03);
		rc(8'hB0, 8'h00);
		$display("test readout done");
		hold(13'h0002, 1);
		rc(8'hB4, 8'h04);
		check("shared rx", {15'h0000, srx_s}, 16'h0001);
		hold(13'h0010, 1);
		rc(8'hB4, 8'h04);
		check("stall tx", {15'h0000, stx}, 16'h0001);
		check("shared tx", {15'h0000, stx_s}, 16'h0000);
		hold(13'h0020, 1);
		rc(8'hB4, 8'h00);
		wc(8'hB4, 8'h08);
		rc(8'hB4, 8'h08);
		check("stall rx", {15'h0000, srx}, 16'h0001);
		check("shared ctl", {8'h00, bus_s_if.rdata}, 16'h0000);
		check("shared rx", {15'h0000, srx_s}, 16'h0000);
		hold(13'h0008, 1);
		rc(8'hB4, 8'h08);
		hold(13'h0010, 1);
		rc(8'hB4, 8'h00);
		hold(13'h0006, 1);
		rc(8'hB4, 8'h0C);
		hold(13'h0001, 1);
		rc(8'hB4, 8'h00);
		$display("test stall done");
		@(posedge mclk) en_rx <= 1'b1;
		rc(8'hB4, 8'h01);
		@(posedge mclk) {en_rx, en_tx} <= 2'b01;
		rc(8'hB4, 8'h01);
		@(posedge mclk) en_tx <= 1'b0;
		rc(8'hB4, 8'h00);
		$display("test enable done");
		wc(8'hB4, 8'h80);
		hold(13'h0100, 1);
		rc(8'hB0, 8'h04);
		check("dir", {15'h0000, dir}, 16'h0001);
		wc(8'hB0, 8'h04);
		hold(13'h0080, 1);
		rc(8'hB0, 8'h00);
		wc(8'hB4, 8'h00);
		hold(13'h0080, 1);
		rc(8'hB0, 8'h04);
		$display("test direction done");
		@(posedge mclk) e0a <= 7'h40;
		e1a <= 7'h15;
		hold(13'h0600, 1);
		e0a <= 7'h05;
		rc(8'hB5, 8'h40);
		rc(8'hB7, 8'h15);
		hold(13'h0040, 1);
		rc(8'hB7, 8'h00);
		$display("test receive done");
		hold(13'h0800, 3);
		rc(8'hCF, 8'h03);
		wc(8'hB4, 8'h60);
		#1 check("write sel", {15'h0000, wbuf}, 16'h0001);
		hold(13'h0800, 2);
		rc(8'hD2, 8'h02);
		rc(8'hCF, 8'h03);
		wc(8'hB4, 8'h40);
		rc(8'hCF, 8'h00);
		hold(13'h0800, 512);
		rc(8'hCE, 8'h02);
		rc(8'hCF, 8'h00);
		// direction change without qualifier: the host must still reselect buffer B
		wc(8'hB4, 8'hA0);
		rc(8'hB4, 8'hA0);
		rc(8'hD2, 8'h00);
		$display("test write count done");
		final_report;
	end
endmodule : usb_endpoint_buffer_control_tb
